// File: src/edbls_core.sv
// Purpose: steer bytes between the internal 16-bit bus and two pin lanes
// Assumes: a bus cycle is one strobe with address, direction and write data
// Notes:   read data returns two cycles after the strobe, pins are registered
//          width select comes from a pin and passes two flops; it must stay fixed
//          internal windows are fixed constants, no memory relocation is modelled
//
// Operation
// RL1: in expansion or microprocessor mode low lane is data bus, else a port
// RL2: 16-bit external read captures low lane into the lower internal byte
// RL3: 16-bit external write drives the lower internal byte on the low lane
// RL4: 16-bit internal read keeps the low lane in high impedance
// RL5: 16-bit internal write still drives internal bus on external lanes
// RL6: 8-bit external read: even address to lower byte, odd to upper
// RL7: 8-bit external write: even drives lower byte, odd drives upper byte
// RL8: 16-bit external read uses high lane only for odd address, else floats
// RL9: 16-bit external write drives the upper internal byte on high lane
// RL10: with 8-bit width the high lane stays a general-purpose port
// RL11: width select low means 16-bit bus, high means 8-bit bus
// RL12: width select is held fixed and never changed between bus cycles
// RL13: each access is decoded internal or external before lanes turn
`default_nettype none
module edbls_core (
   // clock and reset
   input  wire logic                    clk_sys_i,
   input  wire logic                    sys_rst_i,
   // processor mode and external bus width
   input  wire edbls_pkg::edbls_mode_type mode_i,
   input  wire logic                    width_sel_i,
   // one access from the internal bus
   input  wire logic                    acc_strobe_i,
   input  wire logic                    acc_write_i,
   input  wire logic [23:0]             acc_addr_i,
   input  wire logic [15:0]             acc_wdata_i,
   // general-purpose port side of both lanes
   input  wire logic [7:0]              low_port_dout_i,
   input  wire logic [7:0]              low_port_dir_i,
   input  wire logic [7:0]              high_port_dout_i,
   input  wire logic [7:0]              high_port_dir_i,
   // lane pins
   input  wire logic [7:0]              low_data_lane_pins_i,
   input  wire logic [7:0]              high_data_lane_pins_i,
   output logic [7:0]                   low_data_lane_pins_o,
   output logic [7:0]                   low_data_lane_pins_oe_o,
   output logic [7:0]                   high_data_lane_pins_o,
   output logic [7:0]                   high_data_lane_pins_oe_o,
   // port read-back and read return
   output logic [7:0]                   low_port_din_o,
   output logic [7:0]                   high_port_din_o,
   output logic [15:0]                  acc_rdata_o,
   output logic [1:0]                   acc_rbyte_en_o,
   output logic                         acc_rvalid_o,
   output logic                         acc_internal_o
);
   edbls_lane_if low_lane ();
   edbls_lane_if high_lane ();

   typedef enum logic [1:0] {
      EDBLS_IDLE,
      EDBLS_DRIVE,
      EDBLS_SAMPLE
   } edbls_state_type;

   // sequencer state
   edbls_state_type state;
   edbls_state_type next_state;

   // bus role and width; width select is a pin, so it passes two flops
   logic        bus_on;
   logic        next_bus_on;
   logic        width_sync_a;
   logic        next_width_sync_a;
   logic        width_sync_b;
   logic        next_width_sync_b;
   logic        wide;

   // fields of the access taken by the sequencer
   logic        acc_write;
   logic        next_acc_write;
   logic        acc_odd;
   logic        next_acc_odd;
   logic        acc_int;
   logic        next_acc_int;
   logic [15:0] acc_wdata;
   logic [15:0] next_acc_wdata;

   // read return towards the internal bus
   logic [15:0] rdata;
   logic [15:0] next_rdata;
   logic [1:0]  rbyte_en;
   logic [1:0]  next_rbyte_en;
   logic        rvalid;
   logic        next_rvalid;

   // port read-back
   logic [7:0]  low_port_din;
   logic [7:0]  next_low_port_din;
   logic [7:0]  high_port_din;
   logic [7:0]  next_high_port_din;

   // lane decode and drive helpers
   logic        dec_internal;
   logic        low_oe;
   logic        high_oe;
   logic [7:0]  low_byte;
   logic [7:0]  high_byte;

   // classify the access against the internal memory windows
   edbls_addr_dec u_dec (
      .addr_i       (acc_addr_i),
      .low_base_i   (edbls_pkg::INT_LOW_BASE_DEF),
      .low_limit_i  (edbls_pkg::INT_LOW_LIMIT_DEF),
      .high_base_i  (edbls_pkg::INT_HIGH_BASE_DEF),
      .high_limit_i (edbls_pkg::INT_HIGH_LIMIT_DEF),
      .internal_o   (dec_internal)
   );

   // low lane pins
   edbls_lane_drv u_low (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     (low_data_lane_pins_i),
      .lane      (low_lane.drv)
   );

   // high lane pins
   edbls_lane_drv u_high (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     (high_data_lane_pins_i),
      .lane      (high_lane.drv)
   );

   // port side values for both lanes
   assign low_lane.port_dout  = low_port_dout_i;
   assign low_lane.port_dir   = low_port_dir_i;
   assign high_lane.port_dout = high_port_dout_i;
   assign high_lane.port_dir  = high_port_dir_i;

   // lane roles: low lane on the bus in expansion modes, high only at 16 bit
   // the high lane falls back to its port whenever the bus is 8 bits wide
   assign low_lane.bus_mode  = bus_on;            // see RL1
   assign high_lane.bus_mode = bus_on && wide;    // see RL10

   // drive enables: writes always drive, reads float the bus lanes
   always_comb begin
      low_oe  = 1'b0;                             // see RL4
      high_oe = 1'b0;                             // see RL4 see RL8
      if (state == EDBLS_DRIVE && acc_write) begin
         low_oe  = 1'b1;                          // see RL3 see RL5 see RL7
         high_oe = wide;                          // see RL9 see RL5
      end
   end

   // write byte placement on the low lane follows width and address parity
   always_comb begin
      low_byte  = acc_wdata[7:0];                 // see RL3
      high_byte = acc_wdata[15:8];                // see RL9
      if (!wide && acc_odd) begin
         low_byte = acc_wdata[15:8];              // see RL7
      end
   end

   // hand the chosen bytes and enables to the lane drivers
   assign low_lane.bus_oe    = low_oe;
   assign low_lane.bus_dout  = low_byte;
   assign high_lane.bus_oe   = high_oe;
   assign high_lane.bus_dout = high_byte;

   // bus role from the mode, width select through its two-flop synchroniser
   always_comb begin
      next_bus_on       = (mode_i != edbls_pkg::EDBLS_SINGLE_CHIP); // see RL1
      next_width_sync_a = width_sel_i;
      next_width_sync_b = width_sync_a;
   end

   // registers of bus role and width; reset assumes the 16-bit bus
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bus_on       <= 1'b0;
         width_sync_a <= edbls_pkg::WIDTH_SEL_16;
         width_sync_b <= edbls_pkg::WIDTH_SEL_16;
      end else begin
         bus_on       <= next_bus_on;
         width_sync_a <= next_width_sync_a;
         width_sync_b <= next_width_sync_b;
      end
   end

   // only the second flop is read; the level is assumed static (see RL12)
   assign wide = (width_sync_b == edbls_pkg::WIDTH_SEL_16);   // see RL11

   // port read-back: synchronised pin levels, one more register stage
   always_comb begin
      next_low_port_din  = low_lane.pin_in;                  // see RL1
      next_high_port_din = high_lane.pin_in;                 // see RL10
   end

   // registers of the port read-back
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         low_port_din  <= 8'h00;
         high_port_din <= 8'h00;
      end else begin
         low_port_din  <= next_low_port_din;
         high_port_din <= next_high_port_din;
      end
   end

   // access walk in rising edges, edge 0 being the one that takes the strobe:
   //   edge 0  fields latched, the sequencer moves to drive
   //   edge 1  lane flops load the write byte and enable, the pins turn
   //   edge 2  enables drop again; a read captures the synchronised lanes
   // the synchronisers make edge 2 see the levels present at edge 0, so the
   // far side must hold read data from the strobe until the answer stands;
   // strobes during an access or in single-chip mode are dropped silently
   // access sequencing and read capture
   always_comb begin
      next_state         = state;
      next_acc_write     = acc_write;
      next_acc_odd       = acc_odd;
      next_acc_int       = acc_int;
      next_acc_wdata     = acc_wdata;
      next_rdata         = rdata;
      next_rbyte_en      = rbyte_en;
      next_rvalid        = 1'b0;
      unique case (state)
         EDBLS_IDLE: begin
            if (acc_strobe_i && bus_on) begin
               next_acc_write = acc_write_i;
               next_acc_odd   = acc_addr_i[edbls_pkg::ODD_BIT];
               next_acc_int   = dec_internal;     // see RL13
               next_acc_wdata = acc_wdata_i;
               next_state     = EDBLS_DRIVE;
            end
         end
         EDBLS_DRIVE: begin
            next_state = EDBLS_SAMPLE;
         end
         EDBLS_SAMPLE: begin
            next_state    = EDBLS_IDLE;
            next_rdata    = 16'h0000;
            next_rbyte_en = 2'h0;
            if (!acc_write && !acc_int) begin
               if (wide) begin
                  next_rdata[7:0] = low_lane.pin_in;          // see RL2
                  next_rbyte_en   = 2'h1;
                  if (acc_odd) begin
                     next_rdata[15:8] = high_lane.pin_in;     // see RL8
                     next_rbyte_en    = 2'h3;
                  end
               end else if (acc_odd) begin
                  next_rdata[15:8] = low_lane.pin_in;         // see RL6
                  next_rbyte_en    = 2'h2;
               end else begin
                  next_rdata[7:0] = low_lane.pin_in;          // see RL6
                  next_rbyte_en   = 2'h1;
               end
               next_rvalid = 1'b1;
            end
         end
         default: begin
            next_state = EDBLS_IDLE;              // unused code, back to idle
         end
      endcase
   end

   // registers of the sequencer
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state         <= EDBLS_IDLE;
         acc_write     <= 1'b0;
         acc_odd       <= 1'b0;
         acc_int       <= 1'b0;
         acc_wdata     <= 16'h0000;
         rdata         <= 16'h0000;
         rbyte_en      <= 2'h0;
         rvalid        <= 1'b0;
      end else begin
         state         <= next_state;
         acc_write     <= next_acc_write;
         acc_odd       <= next_acc_odd;
         acc_int       <= next_acc_int;
         acc_wdata     <= next_acc_wdata;
         rdata         <= next_rdata;
         rbyte_en      <= next_rbyte_en;
         rvalid        <= next_rvalid;
      end
   end

   // top-level outputs, all straight from registers
   assign low_data_lane_pins_o     = low_lane.pin_out;
   assign low_data_lane_pins_oe_o  = low_lane.pin_oe;
   assign high_data_lane_pins_o    = high_lane.pin_out;
   assign high_data_lane_pins_oe_o = high_lane.pin_oe;
   assign low_port_din_o           = low_port_din;
   assign high_port_din_o          = high_port_din;
   assign acc_rdata_o              = rdata;
   assign acc_rbyte_en_o           = rbyte_en;
   assign acc_rvalid_o             = rvalid;
   assign acc_internal_o           = acc_int;
endmodule : edbls_core
`default_nettype wire

// File: src/edbls_pkg.sv
// Purpose: shared constants for the external data bus lane steering block
// Assumes: 16-bit internal data bus, two 8-bit external lanes
// Notes:   processor mode and width encodings live here
`default_nettype none
package edbls_pkg;
   localparam int unsigned BYTE_W  = 8;
   localparam int unsigned WORD_W  = 16;
   localparam int unsigned ADDR_W  = 24;
   // processor mode encodings
   typedef enum logic [1:0] {
      EDBLS_SINGLE_CHIP = 2'h0,
      EDBLS_MEM_EXPAND  = 2'h1,
      EDBLS_MICROPROC   = 2'h2
   } edbls_mode_type;
   // width-select level meanings
   localparam logic WIDTH_SEL_16 = 1'h0;
   localparam logic WIDTH_SEL_8  = 1'h1;
   // default internal area: peripheral registers and RAM at the bottom
   localparam logic [23:0] INT_LOW_BASE_DEF  = 24'h000000;
   localparam logic [23:0] INT_LOW_LIMIT_DEF = 24'h000FFF;
   // default internal area: program memory
   localparam logic [23:0] INT_HIGH_BASE_DEF  = 24'h001000;
   localparam logic [23:0] INT_HIGH_LIMIT_DEF = 24'h01EFFF;
   localparam int unsigned ODD_BIT = 0;
endpackage : edbls_pkg
`default_nettype wire

// File: src/edbls_lane_if.sv
// Purpose: carrier between the steering core and its lane pin driver
// Assumes: one lane per instance of the driver
// Notes:   bus_* fields come from the core, port_* from the port logic
`default_nettype none
interface edbls_lane_if;
   logic       bus_mode;   // lane serves the data bus
   logic       bus_oe;     // bus wants the lane driven
   logic [7:0] bus_dout;   // byte to drive while on the bus
   logic [7:0] port_dout;  // general-purpose port value
   logic [7:0] port_dir;   // general-purpose direction, one is output
   logic [7:0] pin_in;     // synchronised pin levels
   logic [7:0] pin_out;    // registered pin output
   logic [7:0] pin_oe;     // registered pin output enable
   modport core (output bus_mode, bus_oe, bus_dout, input pin_in);
   modport drv  (input bus_mode, bus_oe, bus_dout, port_dout, port_dir,
                 output pin_in, pin_out, pin_oe);
   modport port (output port_dout, port_dir);
endinterface : edbls_lane_if
`default_nettype wire

// File: src/edbls_lane_drv.sv
// Purpose: one 8-bit lane: input synchroniser and registered pin drivers
// Assumes: pins are split into input, output and output enable
// Notes:   second flop of the synchroniser is the only one read
`default_nettype none
module edbls_lane_drv (
   input  wire logic       clk_sys_i,
   input  wire logic       sys_rst_i,
   input  wire logic [7:0] pin_i,
   edbls_lane_if.drv       lane
);
   logic [7:0] sync_a;
   logic [7:0] sync_b;
   logic [7:0] pin_out;
   logic [7:0] pin_oe;
   logic [7:0] next_pin_out;
   logic [7:0] next_pin_oe;

   // choose bus or port drive for every pin of the lane
   always_comb begin
      if (lane.bus_mode) begin
         next_pin_out = lane.bus_dout;
         next_pin_oe  = {8{lane.bus_oe}};
      end else begin
         next_pin_out = lane.port_dout;
         next_pin_oe  = lane.port_dir;
      end
   end

   // register synchroniser and pin drivers
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sync_a  <= 8'h00;
         sync_b  <= 8'h00;
         pin_out <= 8'h00;
         pin_oe  <= 8'h00;
      end else begin
         sync_a  <= pin_i;
         sync_b  <= sync_a;
         pin_out <= next_pin_out;
         pin_oe  <= next_pin_oe;
      end
   end

   assign lane.pin_in  = sync_b;
   assign lane.pin_out = pin_out;
   assign lane.pin_oe  = pin_oe;
endmodule : edbls_lane_drv
`default_nettype wire

// File: src/edbls_addr_dec.sv
// Purpose: decide whether an address falls in internal memory or registers
// Assumes: two internal windows given as inclusive base and limit
// Notes:   purely combinational, result is registered by the caller
`default_nettype none
module edbls_addr_dec (
   input  wire logic [23:0] addr_i,
   input  wire logic [23:0] low_base_i,
   input  wire logic [23:0] low_limit_i,
   input  wire logic [23:0] high_base_i,
   input  wire logic [23:0] high_limit_i,
   output logic             internal_o
);
   // match against both internal windows
   always_comb begin
      internal_o = ((addr_i >= low_base_i) && (addr_i <= low_limit_i)) ||
                   ((addr_i >= high_base_i) && (addr_i <= high_limit_i));
   end
endmodule : edbls_addr_dec
`default_nettype wire

// File: tb/edbls_assertions.sv
// Purpose: port assertions for the lane steering core
// Assumes: one clock, reset async high
// Notes:   bound into edbls_core at the foot of this file
`default_nettype none
module edbls_assertions (
   input wire logic                      clk_sys_i,
   input wire logic                      sys_rst_i,
   input wire edbls_pkg::edbls_mode_type mode_i,
   input wire logic                      width_sel_i,
   input wire logic                      acc_strobe_i,
   input wire logic                      acc_write_i,
   input wire logic [23:0]               acc_addr_i,
   input wire logic [15:0]               acc_wdata_i,
   input wire logic [7:0]                low_port_dout_i,
   input wire logic [7:0]                low_port_dir_i,
   input wire logic [7:0]                high_port_dout_i,
   input wire logic [7:0]                high_port_dir_i,
   input wire logic [7:0]                low_data_lane_pins_o,
   input wire logic [7:0]                low_data_lane_pins_oe_o,
   input wire logic [7:0]                high_data_lane_pins_o,
   input wire logic [7:0]                high_data_lane_pins_oe_o,
   input wire logic [1:0]                acc_rbyte_en_o,
   input wire logic                      acc_rvalid_o,
   input wire logic                      acc_internal_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   logic        bus, w16, ext, tk;
   logic [2:0]  odd, extp;
   logic [1:0]  sc, up;
   logic [15:0] wd1, wd2;
   // access classification as seen at the ports
   assign w16 = width_sel_i == edbls_pkg::WIDTH_SEL_16;
   assign ext = acc_addr_i > edbls_pkg::INT_HIGH_LIMIT_DEF;
   assign tk  = acc_strobe_i && bus;
   // delayed copies of mode and access fields
   always_ff @(posedge clk_sys_i) begin
      bus  <= mode_i != edbls_pkg::EDBLS_SINGLE_CHIP;
      sc   <= {sc[0], mode_i == edbls_pkg::EDBLS_SINGLE_CHIP};
      odd  <= {odd[1:0], acc_addr_i[0]};
      extp <= {extp[1:0], ext};
      wd1  <= acc_wdata_i;
      wd2  <= wd1;
   end
   // edges since reset, hides the reset values of the outputs
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) up <= 2'h0;
      else if (up != 2'h3) up <= up + 2'h1;
   end
   chk_wr_low16: assert property (tk && acc_write_i && w16 |-> ##2
      low_data_lane_pins_oe_o == 8'hFF && low_data_lane_pins_o == wd2[7:0]) else $error("low wr");
   chk_wr_high16: assert property (tk && acc_write_i && w16 |-> ##2
      high_data_lane_pins_oe_o == 8'hFF && high_data_lane_pins_o == wd2[15:8]) else $error("hi wr");
   chk_wr_lane8: assert property (tk && acc_write_i && !w16 |-> ##2
      low_data_lane_pins_o == (odd[1] ? wd2[15:8] : wd2[7:0])) else $error("8-bit wr");
   chk_rd_bytes: assert property (tk && !acc_write_i && ext |-> ##3 acc_rvalid_o &&
      acc_rbyte_en_o == (w16 ? {odd[2], 1'b1} : {odd[2], ~odd[2]})) else $error("rd bytes");
   chk_int_float: assert property (tk && !acc_write_i && !ext && w16 |-> ##1 (!acc_rvalid_o &&
      low_data_lane_pins_oe_o == 8'h00 && high_data_lane_pins_oe_o == 8'h00)[*3]) else $error("int rd");
   chk_int_flag: assert property (tk |-> ##3 acc_internal_o == !extp[2])
      else $error("decode");
   chk_port_low: assert property (up == 2'h3 && sc == 2'h3 |-> low_data_lane_pins_o ==
      $past(low_port_dout_i) && low_data_lane_pins_oe_o == $past(low_port_dir_i)) else $error("port");
   chk_port_high: assert property (up == 2'h3 && !w16 |-> high_data_lane_pins_o ==
      $past(high_port_dout_i) && high_data_lane_pins_oe_o == $past(high_port_dir_i)) else $error("hi");
   cov_wr: cover property (tk && acc_write_i);
   cov_rd: cover property (tk && !acc_write_i && ext);
   cov_int: cover property (tk && !acc_write_i && !ext);
endmodule // edbls_assertions
bind edbls_core edbls_assertions i_edbls_assertions (.*);
`default_nettype wire

// File: tb/edbls_mem_model.sv
// Purpose: external byte memory on the two data lanes
// Assumes: address lines seen as the access address
// Notes:   released lanes show a pattern that flips every cycle
`default_nettype none
module edbls_mem_model (
   input  wire logic        clk_sys_i,
   input  wire logic        acc_strobe_i,
   input  wire logic        acc_write_i,
   input  wire logic        width_sel_i,
   input  wire logic [23:0] acc_addr_i,
   input  wire logic [7:0]  dlo_i,
   input  wire logic [7:0]  elo_i,
   input  wire logic [7:0]  dhi_i,
   input  wire logic [7:0]  ehi_i,
   output logic [7:0]       plo_o,
   output logic [7:0]       phi_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:31];
   logic [4:0] a, ra;
   logic       w, drv, tog = 1'b0;
   logic [2:0] rd = 3'h0;
   logic [7:0] mlo, mhi;
   // latch the access and store what the device drives
   always @(posedge clk_sys_i) begin
      tog <= ~tog;
      rd  <= acc_strobe_i ? {3{~acc_write_i}} : rd >> 1;
      if (acc_strobe_i) begin
         a <= acc_addr_i[4:0];
         w <= acc_write_i;
      end
      if (w && elo_i == 8'hFF) begin
         if (width_sel_i) mem[a] <= dlo_i;
         else begin
            mem[{a[4:1], 1'b0}] <= dlo_i;
            mem[{a[4:1], 1'b1}] <= dhi_i;
         end
      end
   end
   // answer reads, resolve each pin from both drivers
   assign ra    = acc_strobe_i ? acc_addr_i[4:0] : a;
   assign drv   = (acc_strobe_i && !acc_write_i) || rd != 3'h0;
   assign mlo   = !drv ? {8{tog}} ^ 8'h5A : width_sel_i ? mem[ra] : mem[{ra[4:1], 1'b0}];
   assign mhi   = drv && !width_sel_i ? mem[{ra[4:1], 1'b1}] : {8{tog}} ^ 8'hA5;
   assign plo_o = (elo_i & dlo_i) | (~elo_i & mlo);
   assign phi_o = (ehi_i & dhi_i) | (~ehi_i & mhi);
endmodule // edbls_mem_model
`default_nettype wire

// File: tb/testbench.sv
// Purpose: self-checking bench for the lane steering core
// Assumes: 25 MHz clock, inputs change on the falling edge
// Notes:   width select only moves while reset is held
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, width_sel_i = 1'b0;
   logic acc_strobe_i = 1'b0, acc_write_i = 1'b0;
   edbls_pkg::edbls_mode_type mode_i = edbls_pkg::EDBLS_MEM_EXPAND;
   logic [23:0] acc_addr_i = 24'h000000;
   logic [15:0] acc_wdata_i = 16'h0000, acc_rdata_o, rd;
   logic [7:0]  low_port_dout_i = 8'h3C, low_port_dir_i = 8'h0F;
   logic [7:0]  high_port_dout_i = 8'hA6, high_port_dir_i = 8'hF0;
   logic [7:0]  low_data_lane_pins_i, high_data_lane_pins_i, low_port_din_o, high_port_din_o;
   logic [7:0]  low_data_lane_pins_o, low_data_lane_pins_oe_o, lo, le, hi, he;
   logic [7:0]  high_data_lane_pins_o, high_data_lane_pins_oe_o;
   logic [1:0]  acc_rbyte_en_o, be;
   logic        acc_rvalid_o, acc_internal_o, rv, in_f;
   int          err_total = 0, cmp_count = 0;
   // core under test and the memory on its lanes
   edbls_core i_edbls_core (.*);
   edbls_mem_model i_edbls_mem_model (.clk_sys_i, .acc_strobe_i, .acc_write_i, .width_sel_i,
      .acc_addr_i, .dlo_i(low_data_lane_pins_o), .elo_i(low_data_lane_pins_oe_o),
      .dhi_i(high_data_lane_pins_o), .ehi_i(high_data_lane_pins_oe_o),
      .plo_o(low_data_lane_pins_i), .phi_o(high_data_lane_pins_i));
   always #20 clk_sys_i = ~clk_sys_i;
   task check(input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task results;
      $display("mismatches %0d comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // width only changes while the core is held in reset
   task rst(input logic w);
      @(negedge clk_sys_i);
      sys_rst_i = 1'b1;
      width_sel_i = w;
      repeat (2) @(negedge clk_sys_i);
      sys_rst_i = 1'b0;
      repeat (2) @(negedge clk_sys_i);
   endtask
   // one access: write pins stand after strobe edge + 1, read answer after + 2
   task acc(input logic w, input logic [23:0] a, input logic [15:0] d);
      @(negedge clk_sys_i);
      acc_strobe_i = 1'b1;
      acc_write_i = w;
      acc_addr_i = a;
      acc_wdata_i = d;
      @(negedge clk_sys_i);
      acc_strobe_i = 1'b0;
      @(negedge clk_sys_i);
      {lo, le, hi, he} = {low_data_lane_pins_o, low_data_lane_pins_oe_o,
                          high_data_lane_pins_o, high_data_lane_pins_oe_o};
      @(negedge clk_sys_i);
      {rv, rd, be, in_f} = {acc_rvalid_o, acc_rdata_o, acc_rbyte_en_o, acc_internal_o};
   endtask
   task t_port;
      mode_i = edbls_pkg::EDBLS_SINGLE_CHIP;
      acc(1'b1, 24'h100000, 16'hFFFF);
      check({le, lo}, {low_port_dir_i, low_port_dout_i});
      repeat (2) @(negedge clk_sys_i);
      check({8'h00, low_port_din_o & low_port_dir_i},
            {8'h00, low_port_dout_i & low_port_dir_i});
      mode_i = edbls_pkg::EDBLS_MEM_EXPAND;
   endtask
   task t_ext16;
      acc(1'b1, 24'h100002, 16'hA55A);
      check({hi, lo}, 16'hA55A);
      check({he, le}, 16'hFFFF);
      acc(1'b0, 24'h100002, 16'h0000);
      check(rd, 16'h005A);
      check({he, 6'h00, be}, 16'h0001);
      acc(1'b0, 24'h100003, 16'h0000);
      check(rd, 16'hA55A);
      check({rv, 13'h0000, be}, 16'h8003);
   endtask
   task t_int16;
      acc(1'b1, 24'h000200, 16'h1234);
      check({hi, lo}, 16'h1234);
      acc(1'b0, 24'h01EFFF, 16'h0000);
      check({rv, 6'h00, in_f, le}, 16'h0100);
      acc(1'b0, 24'h01F000, 16'h0000);
      check({rv, 14'h0000, in_f}, 16'h8000);
   endtask
   task t_ext8;
      mode_i = edbls_pkg::EDBLS_MICROPROC;
      rst(edbls_pkg::WIDTH_SEL_8);
      acc(1'b1, 24'h200004, 16'h00C3);
      check({le, lo}, 16'hFFC3);
      acc(1'b1, 24'h200005, 16'h7E00);
      check({le, lo}, 16'hFF7E);
      check({he, hi}, {high_port_dir_i, high_port_dout_i});
      check({8'h00, high_port_din_o & high_port_dir_i},
            {8'h00, high_port_dout_i & high_port_dir_i});
      acc(1'b0, 24'h200004, 16'h0000);
      check(rd, 16'h00C3);
      acc(1'b0, 24'h200005, 16'h0000);
      check({rd[15:8], 6'h00, be}, 16'h7E02);
   endtask
   initial begin
      rst(edbls_pkg::WIDTH_SEL_16);
      t_port();
      t_ext16();
      t_int16();
      t_ext8();
      results();
   end
   // watchdog far beyond the some sixty cycles the tests need
   initial begin
      #40000;
      err_total++;
      results();
   end
endmodule // testbench
`default_nettype wire
